// File: isrb_pkg.sv
package isrb_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  ISRB_MIN_IVL_OFS = 8'h00;
  localparam logic [7:0]  ISRB_REALIGN_OFS = 8'h04;
  localparam logic [7:0]  ISRB_STATUS_OFS  = 8'h08;
  localparam logic [7:0]  ISRB_OUTPUTS_OFS = 8'h0C;

  // ---------------------------------------------------------------
  // Realign command bit positions (write one to release)
  // ---------------------------------------------------------------
  localparam int ISRB_RA_EQUIP_POS  = 0;
  localparam int ISRB_RA_SEQ_POS    = 2;
  localparam int ISRB_RA_RECIRC_POS = 4;
  localparam int ISRB_RA_ISOL_POS   = 6;

  // ---------------------------------------------------------------
  // Status field positions (two bits each, one per train)
  // ---------------------------------------------------------------
  localparam int ISRB_ST_ACT_POS    = 0;
  localparam int ISRB_ST_BLK_POS    = 2;
  localparam int ISRB_ST_TAKE_POS   = 4;
  localparam int ISRB_ST_IVL_POS    = 6;
  localparam int ISRB_ST_PZRBLK_POS = 8;
  localparam int ISRB_ST_SLBLK_POS  = 10;
  localparam int ISRB_ST_P4_POS     = 12;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int ISRB_CLK_MHZ       = 125;
  localparam int ISRB_DEBOUNCE_NS   = 1000;
  localparam int ISRB_DEBOUNCE_CYC  = (ISRB_DEBOUNCE_NS * ISRB_CLK_MHZ) / 1000;
  localparam int ISRB_MIN_IVL_US    = 1000;
  localparam int ISRB_MIN_IVL_CYC   = ISRB_MIN_IVL_US * ISRB_CLK_MHZ;
  localparam int ISRB_SEQ_DELAY_US  = 100;
  localparam int ISRB_SEQ_DELAY_CYC = ISRB_SEQ_DELAY_US * ISRB_CLK_MHZ;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] ISRB_ZERO_RST = 32'h0000_0000;

endpackage

// File: isrb_top.sv
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module isrb_top
  import isrb_pkg::*;
#(
  parameter int MIN_IVL_CYC   = ISRB_MIN_IVL_CYC,
  parameter int SEQ_DELAY_CYC = ISRB_SEQ_DELAY_CYC,
  parameter int DEBOUNCE_CYC  = ISRB_DEBOUNCE_CYC,
  parameter int LOOPS         = 4
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  initiate_in,
  input  wire logic [1:0]  pzr_initiate_in,
  input  wire logic [1:0]  steamline_initiate_in,
  input  wire logic [1:0]  pzr_permissive_in,
  input  wire logic [1:0]  steamline_permissive_in,
  input  wire logic [1:0]  pzr_block_sw,
  input  wire logic [1:0]  steamline_block_sw,
  input  wire logic [1:0]  reset_sw,
  input  wire logic [1:0]  block_sw,
  input  wire logic [1:0]  manual_si_sw,
  input  wire logic [1:0]  trip_bkr_aux_in,
  input  wire logic [1:0]  refuel_storage_tank_level_low,
  input  wire logic [3:0]  loop_isol_sw,
  input  wire logic [1:0]  system_isol_sw,
  output logic      [1:0]  actuate,
  output logic      [1:0]  auto_blocked,
  output logic      [1:0]  equip_actuate,
  output logic      [1:0]  seq_load_actuate,
  output logic      [1:0]  recirc_align,
  output logic      [3:0]  loop_isol_close
);

  // Counters and loop mapping serve only these ranges
  if (LOOPS != 4 || MIN_IVL_CYC < 1 || SEQ_DELAY_CYC < 1 || DEBOUNCE_CYC < 1 ||
      DEBOUNCE_CYC > 65535) begin : g_param_check
    $error("isrb_top: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // Input conditioning
  // ---------------------------------------------------------------
  localparam int NIN = 30;
  localparam int DBW = 16;

  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  logic [NIN-1:0] clean_reg;

  assign raw_in = {system_isol_sw, loop_isol_sw, refuel_storage_tank_level_low,
                   trip_bkr_aux_in, manual_si_sw, block_sw, reset_sw,
                   steamline_block_sw, pzr_block_sw, steamline_permissive_in,
                   pzr_permissive_in, steamline_initiate_in, pzr_initiate_in,
                   initiate_in};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_deb
      logic [DBW-1:0] cnt_reg;
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          cnt_reg        <= '0;
          clean_reg[g]   <= 1'b0;
        end else if (sync2_reg[g] == clean_reg[g]) begin
          cnt_reg <= '0;
        end else if (cnt_reg == DBW'(DEBOUNCE_CYC - 1)) begin
          cnt_reg      <= '0;
          clean_reg[g] <= sync2_reg[g];
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  endgenerate

  function automatic logic [1:0] pick2(input logic [NIN-1:0] v, input int pos);
    pick2 = v[pos +: 2];
  endfunction

  logic [1:0] init_c;
  logic [1:0] pzr_init_c;
  logic [1:0] sl_init_c;
  logic [1:0] pzr_perm_c;
  logic [1:0] sl_perm_c;
  logic [1:0] pzr_blksw_c;
  logic [1:0] sl_blksw_c;
  logic [1:0] reset_c;
  logic [1:0] block_c;
  logic [1:0] man_c;
  logic [1:0] p4_c;
  logic [1:0] tank_low_c;
  logic [3:0] loop_c;
  logic [1:0] sys_c;

  assign init_c      = pick2(clean_reg, 0);
  assign pzr_init_c  = pick2(clean_reg, 2);
  assign sl_init_c   = pick2(clean_reg, 4);
  assign pzr_perm_c  = pick2(clean_reg, 6);
  assign sl_perm_c   = pick2(clean_reg, 8);
  assign pzr_blksw_c = pick2(clean_reg, 10);
  assign sl_blksw_c  = pick2(clean_reg, 12);
  assign reset_c     = pick2(clean_reg, 14);
  assign block_c     = pick2(clean_reg, 16);
  assign man_c       = pick2(clean_reg, 18);
  assign p4_c        = pick2(clean_reg, 20);
  assign tank_low_c  = pick2(clean_reg, 22);
  assign loop_c      = clean_reg[27:24];
  assign sys_c       = pick2(clean_reg, 28);

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [31:0] min_ivl_reg;
  logic [9:0]  realign_pulse;
  logic        wb_req;
  logic        wb_wr;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      min_ivl_reg <= 32'(MIN_IVL_CYC);
    end else if (wb_wr && wb_adr_i == ISRB_MIN_IVL_OFS) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          min_ivl_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  assign realign_pulse = (wb_wr && wb_adr_i == ISRB_REALIGN_OFS && wb_sel_i[0] && wb_sel_i[1])
                         ? wb_dat_i[9:0] : 10'h000;

  // ---------------------------------------------------------------
  // Per-train actuation logic
  // ---------------------------------------------------------------
  logic [1:0] act_reg;
  logic [1:0] blk_reg;
  logic [1:0] take_reg;
  logic [1:0] ivl_done;
  logic [1:0] pzr_blk_reg;
  logic [1:0] sl_blk_reg;
  logic       man_any;

  // either manual switch drives both trains
  assign man_any = |man_c;

  generate
    for (g = 0; g < 2; g++) begin : g_train
      logic        auto_init;
      logic        auto_prev_reg;
      logic        auto_rise;
      logic        auto_eff;
      logic        act_prev_reg;
      logic [31:0] ivl_cnt_reg;
      logic [31:0] seq_cnt_reg;
      logic        seq_run_reg;

      // startup blocks removed by plant conditions
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pzr_blk_reg[g] <= 1'b0;
          sl_blk_reg[g]  <= 1'b0;
        end else begin
          pzr_blk_reg[g] <= pzr_perm_c[g] & (pzr_blk_reg[g] | pzr_blksw_c[g]);
          sl_blk_reg[g]  <= sl_perm_c[g] & (sl_blk_reg[g] | sl_blksw_c[g]);
        end
      end

      assign auto_init = init_c[g] | (pzr_init_c[g] & ~pzr_blk_reg[g])
                         | (sl_init_c[g] & ~sl_blk_reg[g]);
      assign auto_rise = auto_init & ~auto_prev_reg;

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          auto_prev_reg <= 1'b0;
          act_prev_reg  <= 1'b0;
        end else begin
          auto_prev_reg <= auto_init;
          act_prev_reg  <= act_reg[g];
        end
      end

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          ivl_cnt_reg <= '0;
        end else if (act_reg[g] && !act_prev_reg) begin
          ivl_cnt_reg <= 32'h0000_0001;
        end else if (act_reg[g] && ivl_cnt_reg < min_ivl_reg) begin
          ivl_cnt_reg <= ivl_cnt_reg + 32'h0000_0001;
        end
      end

      assign ivl_done[g] = act_reg[g] && !(act_reg[g] && !act_prev_reg)
                           && ivl_cnt_reg >= min_ivl_reg;

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          take_reg[g] <= 1'b0;
        end else if (!auto_init) begin
          take_reg[g] <= 1'b0;
        end else if (auto_rise && reset_c[0] && reset_c[1]) begin
          take_reg[g] <= 1'b1;
        end
      end

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          blk_reg[g] <= 1'b0;
        end else if (!p4_c[g]) begin
          blk_reg[g] <= 1'b0;
        end else if (block_c[g] && ivl_done[g]) begin
          blk_reg[g] <= 1'b1;
        end
      end

      assign auto_eff = auto_init & ~blk_reg[g] & ~take_reg[g]
                        & ~(auto_rise & reset_c[0] & reset_c[1]);

      // train latches on its own initiation or on either manual switch
      // manual always sets; set wins over reset
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          act_reg[g] <= 1'b0;
        end else if (auto_eff || man_any) begin
          act_reg[g] <= 1'b1;
        end else if (reset_c[g] && ivl_done[g]) begin
          act_reg[g] <= 1'b0;
        end
      end

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          equip_actuate[g] <= 1'b0;
        end else if (act_reg[g]) begin
          equip_actuate[g] <= 1'b1;
        end else if (realign_pulse[ISRB_RA_EQUIP_POS + g]) begin
          equip_actuate[g] <= 1'b0;
        end
      end

      // delay runs after latch, reset cannot stop it
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          seq_run_reg <= 1'b0;
          seq_cnt_reg <= '0;
        end else if (act_reg[g] && !act_prev_reg && !seq_load_actuate[g]) begin
          seq_run_reg <= 1'b1;
          seq_cnt_reg <= '0;
        end else if (seq_run_reg) begin
          seq_cnt_reg <= seq_cnt_reg + 32'h0000_0001;
          if (seq_cnt_reg == 32'(SEQ_DELAY_CYC - 1)) begin
            seq_run_reg <= 1'b0;
          end
        end
      end

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          seq_load_actuate[g] <= 1'b0;
        end else if (seq_run_reg && seq_cnt_reg == 32'(SEQ_DELAY_CYC - 1)) begin
          seq_load_actuate[g] <= 1'b1;
        end else if (realign_pulse[ISRB_RA_SEQ_POS + g]) begin
          seq_load_actuate[g] <= 1'b0;
        end
      end

      // switchover completes on low tank level
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          recirc_align[g] <= 1'b0;
        end else if (equip_actuate[g] && tank_low_c[g]) begin
          recirc_align[g] <= 1'b1;
        end else if (realign_pulse[ISRB_RA_RECIRC_POS + g]) begin
          recirc_align[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign actuate = act_reg;

  assign auto_blocked = blk_reg | take_reg;

  // ---------------------------------------------------------------
  // Steam line isolation
  // ---------------------------------------------------------------
  generate
    for (g = 0; g < LOOPS; g++) begin : g_loop
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          loop_isol_close[g] <= 1'b0;
        end else if (loop_c[g] || (|sys_c)) begin
          loop_isol_close[g] <= 1'b1;
        end else if (realign_pulse[ISRB_RA_ISOL_POS + g]) begin
          loop_isol_close[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] outputs_word;

  always_comb begin
    status_word = ISRB_ZERO_RST;
    status_word[ISRB_ST_ACT_POS +: 2]    = act_reg;
    status_word[ISRB_ST_BLK_POS +: 2]    = blk_reg;
    status_word[ISRB_ST_TAKE_POS +: 2]   = take_reg;
    status_word[ISRB_ST_IVL_POS +: 2]    = ivl_done;
    status_word[ISRB_ST_PZRBLK_POS +: 2] = pzr_blk_reg;
    status_word[ISRB_ST_SLBLK_POS +: 2]  = sl_blk_reg;
    status_word[ISRB_ST_P4_POS +: 2]     = p4_c;
    outputs_word = ISRB_ZERO_RST;
    outputs_word[ISRB_RA_EQUIP_POS +: 2]  = equip_actuate;
    outputs_word[ISRB_RA_SEQ_POS +: 2]    = seq_load_actuate;
    outputs_word[ISRB_RA_RECIRC_POS +: 2] = recirc_align;
    outputs_word[ISRB_RA_ISOL_POS +: 4]   = loop_isol_close;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_dat_o <= ISRB_ZERO_RST;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        ISRB_MIN_IVL_OFS: wb_dat_o <= min_ivl_reg;
        ISRB_STATUS_OFS:  wb_dat_o <= status_word;
        ISRB_OUTPUTS_OFS: wb_dat_o <= outputs_word;
        default:          wb_dat_o <= ISRB_ZERO_RST;
      endcase
    end
  end

endmodule

// File: isrb_monitor.sv
`timescale 1ns/1ps
module isrb_monitor
  import isrb_pkg::*;
#(
  parameter int MIN_IVL_CYC = ISRB_MIN_IVL_CYC
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic       wb_ack_o,
  input wire logic [1:0] trip_bkr_aux_in,
  input wire logic [1:0] manual_si_sw,
  input wire logic [1:0] system_isol_sw,
  input wire logic [1:0] actuate,
  input wire logic [1:0] auto_blocked,
  input wire logic [1:0] equip_actuate,
  input wire logic [1:0] seq_load_actuate,
  input wire logic [3:0] loop_isol_close
);
  int   act_cnt;
  logic realign_wr;
  assign realign_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ISRB_REALIGN_OFS;
  // Cycles that train A has stayed actuated
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      act_cnt <= 0;
    end else if (!actuate[0]) begin
      act_cnt <= 0;
    end else if (act_cnt < 1000000) begin
      act_cnt <= act_cnt + 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reset_after_ivl: assert property ($fell(actuate[0]) |-> act_cnt >= MIN_IVL_CYC)
    else $error("actuate cleared before minimum interval");
  a_seal_on_clear: assert property ($fell(actuate[0]) |-> equip_actuate[0] && seq_load_actuate[0])
    else $error("sealed outputs dropped with actuate");
  a_equip_release: assert property ($fell(equip_actuate[0]) |-> $past(realign_wr))
    else $error("equipment released without realign");
  a_seq_not_early: assert property ($rose(actuate[0]) && !seq_load_actuate[0] |=> !seq_load_actuate[0] [*8])
    else $error("sequenced load too early");
  a_seq_in_time: assert property ($rose(actuate[0]) |-> ##[1:60] seq_load_actuate[0])
    else $error("sequenced load missing");
  a_sys_isol_all: assert property ((|system_isol_sw) [*8] |-> ##[0:4] (&loop_isol_close))
    else $error("system isolation not closing all loops");
  a_manual_all: assert property (manual_si_sw[1] [*8] |-> ##[0:4] (&actuate && &equip_actuate))
    else $error("manual switch not actuating both trains");
  a_untrip_unblock: assert property (!trip_bkr_aux_in[0] [*8] |-> ##[0:4] !auto_blocked[0])
    else $error("block held with reactor not tripped");
  c_blocked: cover property ($rose(auto_blocked[0]));
  c_seq_load: cover property ($rose(seq_load_actuate[0]));
  c_realign: cover property ($fell(equip_actuate[0]));
endmodule

bind isrb_top isrb_monitor #(.MIN_IVL_CYC(MIN_IVL_CYC)) u_mon (.clock(clock), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .trip_bkr_aux_in(trip_bkr_aux_in), .manual_si_sw(manual_si_sw),
  .system_isol_sw(system_isol_sw), .actuate(actuate), .auto_blocked(auto_blocked),
  .equip_actuate(equip_actuate), .seq_load_actuate(seq_load_actuate),
  .loop_isol_close(loop_isol_close));

// File: isrb_plant.sv
`timescale 1ns/1ps
module isrb_plant #(
  parameter int DRAIN_CYC = 30
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [1:0] pump_run,
  output logic      [1:0] tank_low
);
  int drain_cnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      drain_cnt <= 0;
      tank_low  <= 2'b00;
    end else begin
      if (|pump_run && drain_cnt < DRAIN_CYC) begin
        drain_cnt <= drain_cnt + 1;
      end
      tank_low <= {2{drain_cnt >= DRAIN_CYC}};
    end
  end
endmodule

// File: isrb_bench.sv
`timescale 1ns/1ps
module isrb_bench
  import isrb_pkg::*;
;
  localparam int          MIN_IVL = 40;
  localparam logic [31:0] act_m   = 32'h3 << ISRB_ST_ACT_POS;
  localparam logic [31:0] blk_m   = 32'h3 << ISRB_ST_BLK_POS;
  localparam logic [31:0] take_m  = 32'h3 << ISRB_ST_TAKE_POS;
  localparam logic [31:0] pzr_m   = 32'h3 << ISRB_ST_PZRBLK_POS;
  localparam logic [31:0] sl_m    = 32'h3 << ISRB_ST_SLBLK_POS;
  localparam logic [31:0] eq_m    = 32'h3 << ISRB_RA_EQUIP_POS;
  localparam logic [31:0] sq_m    = 32'h3 << ISRB_RA_SEQ_POS;
  localparam logic [31:0] rc_m    = 32'h3 << ISRB_RA_RECIRC_POS;
  localparam logic [31:0] lp_m    = 32'hF << ISRB_RA_ISOL_POS;
  typedef struct {logic [7:0] adr; logic [31:0] msk; logic [31:0] val;} isrb_exp_t;
  logic        clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rnd;
  logic [3:0]  wb_sel_i, loop_isol_sw, loop_isol_close;
  logic [1:0]  initiate_in, pzr_permissive_in, pzr_block_sw, reset_sw, block_sw;
  logic [1:0]  manual_si_sw, trip_bkr_aux_in, tank_low, system_isol_sw, actuate;
  logic [1:0]  auto_blocked, equip_actuate, seq_load_actuate, recirc_align;
  logic [1:0]  pzr_initiate_in, steamline_initiate_in;
  logic [1:0]  steamline_permissive_in, steamline_block_sw;
  logic [9:0]  out_pins;
  int          bad_count, tests_run;
  isrb_exp_t   exp_q[$];

  // Sealed output pins in the OUTPUTS word layout
  assign out_pins = {loop_isol_close, recirc_align, seq_load_actuate, equip_actuate};

  always #4 clock = ~clock;

  isrb_top #(.MIN_IVL_CYC(MIN_IVL), .SEQ_DELAY_CYC(10), .DEBOUNCE_CYC(2)) dut (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .initiate_in(initiate_in), .pzr_initiate_in(pzr_initiate_in),
    .steamline_initiate_in(steamline_initiate_in), .pzr_permissive_in(pzr_permissive_in),
    .steamline_permissive_in(steamline_permissive_in), .pzr_block_sw(pzr_block_sw),
    .steamline_block_sw(steamline_block_sw),
    .reset_sw(reset_sw), .block_sw(block_sw), .manual_si_sw(manual_si_sw),
    .trip_bkr_aux_in(trip_bkr_aux_in), .refuel_storage_tank_level_low(tank_low),
    .loop_isol_sw(loop_isol_sw), .system_isol_sw(system_isol_sw), .actuate(actuate),
    .auto_blocked(auto_blocked), .equip_actuate(equip_actuate),
    .seq_load_actuate(seq_load_actuate), .recirc_align(recirc_align),
    .loop_isol_close(loop_isol_close));

  isrb_plant #(.DRAIN_CYC(30)) plant (.clock(clock), .rst(rst), .pump_run(equip_actuate),
    .tank_low(tank_low));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic settle();
    cyc(12);
  endtask

  task automatic chk_pin(input logic [1:0] seen, input logic [1:0] want);
    tests_run++;
    if (seen !== want) begin
      $display("Error auto_blocked expected %h seen %h", want, seen);
      bad_count++;
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    int n;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, dat, sel};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      final_report();
    end
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] val);
    exp_q.push_back('{adr, msk, val});
    wb(1'b0, adr, 32'h0, 4'hF);
  endtask

  // Read results are matched against the oldest expectation
  always @(posedge clock) begin
    isrb_exp_t e;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      tests_run++;
      if ((wb_dat_o & e.msk) !== (e.val & e.msk)) begin
        $display("Error reg %h expected %h seen %h", e.adr, e.val & e.msk, wb_dat_o & e.msk);
        bad_count++;
      end
      if (e.adr == ISRB_STATUS_OFS && e.msk[1:0] == 2'b11 &&
          actuate !== e.val[1:0]) begin
        $display("Error actuate expected %h seen %h", e.val[1:0], actuate);
        bad_count++;
      end
      if (e.adr == ISRB_OUTPUTS_OFS &&
          (out_pins & e.msk[9:0]) !== (e.val[9:0] & e.msk[9:0])) begin
        $display("Error output pins expected %h seen %h", e.val[9:0] & e.msk[9:0],
                 out_pins & e.msk[9:0]);
        bad_count++;
      end
    end
  end

  task automatic pulse_rst();
    @(posedge clock);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    {initiate_in, pzr_permissive_in, pzr_block_sw, reset_sw, block_sw} = '0;
    {pzr_initiate_in, steamline_initiate_in, steamline_permissive_in, steamline_block_sw} = '0;
    {manual_si_sw, loop_isol_sw, system_isol_sw} = '0;
    trip_bkr_aux_in = 2'b11;
    bad_count = 0;
    tests_run = 0;
    rnd = 32'h5A894219;
    cyc(2);
    rst <= 1'b0;
    rd(ISRB_MIN_IVL_OFS, '1, 32'(MIN_IVL));
    rd(8'h10, '1, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
    rd(ISRB_OUTPUTS_OFS, '1, 32'h0);
    rnd = xs(rnd);
    wb(1'b1, ISRB_MIN_IVL_OFS, rnd, 4'h1);
    rd(ISRB_MIN_IVL_OFS, '1, {24'h0, rnd[7:0]});
    wb(1'b1, ISRB_MIN_IVL_OFS, 32'(MIN_IVL), 4'hF);
    // Startup blocks hold off initiation until the permissive clears
    {pzr_permissive_in, steamline_permissive_in} <= 4'hF;
    {pzr_block_sw, steamline_block_sw} <= 4'hF;
    settle();
    {pzr_block_sw, steamline_block_sw} <= 4'h0;
    {pzr_initiate_in, steamline_initiate_in} <= 4'hF;
    settle();
    rd(ISRB_STATUS_OFS, pzr_m | sl_m | act_m, pzr_m | sl_m);
    steamline_permissive_in <= 2'b00;
    settle();
    rd(ISRB_STATUS_OFS, pzr_m | sl_m | act_m, pzr_m | act_m);
    pzr_permissive_in <= 2'b00;
    {pzr_initiate_in, steamline_initiate_in} <= 4'h0;
    settle();
    rd(ISRB_STATUS_OFS, pzr_m | sl_m, 32'h0);
    pulse_rst();
    // One train in reset, early block, sealing, realign, block and unblock
    reset_sw <= 2'b01;
    settle();
    initiate_in <= 2'b11;
    settle();
    block_sw <= 2'b11;
    cyc(8);
    block_sw <= 2'b00;
    rd(ISRB_STATUS_OFS, act_m | take_m | blk_m, act_m);
    cyc(40);
    rd(ISRB_OUTPUTS_OFS, eq_m | sq_m | rc_m, eq_m | sq_m | rc_m);
    reset_sw <= 2'b00;
    initiate_in <= 2'b00;
    block_sw <= 2'b11;
    settle();
    block_sw <= 2'b00;
    rd(ISRB_STATUS_OFS, blk_m, blk_m);
    chk_pin(auto_blocked, 2'b11);
    reset_sw <= 2'b11;
    settle();
    reset_sw <= 2'b00;
    settle();
    rd(ISRB_STATUS_OFS, act_m, 32'h0);
    rd(ISRB_OUTPUTS_OFS, eq_m | sq_m, eq_m | sq_m);
    wb(1'b1, ISRB_REALIGN_OFS, 32'h1 << ISRB_RA_EQUIP_POS, 4'hF);
    rd(ISRB_OUTPUTS_OFS, eq_m, 32'h2 << ISRB_RA_EQUIP_POS);
    initiate_in <= 2'b11;
    settle();
    rd(ISRB_STATUS_OFS, act_m | blk_m, blk_m);
    chk_pin(auto_blocked, 2'b11);
    manual_si_sw <= 2'b10;
    settle();
    rd(ISRB_STATUS_OFS, act_m, act_m);
    rd(ISRB_OUTPUTS_OFS, eq_m, eq_m);
    manual_si_sw <= 2'b00;
    trip_bkr_aux_in <= 2'b00;
    settle();
    rd(ISRB_STATUS_OFS, blk_m, 32'h0);
    chk_pin(auto_blocked, 2'b00);
    initiate_in <= 2'b00;
    trip_bkr_aux_in <= 2'b11;
    // Two-train takeover, release, fresh initiation
    pulse_rst();
    reset_sw <= 2'b11;
    settle();
    initiate_in <= 2'b11;
    settle();
    rd(ISRB_STATUS_OFS, act_m | take_m, take_m);
    chk_pin(auto_blocked, 2'b11);
    rd(ISRB_OUTPUTS_OFS, eq_m | sq_m, 32'h0);
    reset_sw <= 2'b00;
    settle();
    rd(ISRB_STATUS_OFS, act_m, 32'h0);
    initiate_in <= 2'b00;
    settle();
    initiate_in <= 2'b11;
    settle();
    rd(ISRB_STATUS_OFS, act_m | take_m, act_m);
    initiate_in <= 2'b00;
    cyc(60);
    // Per-loop and system isolation
    pulse_rst();
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      loop_isol_sw <= (i < 4) ? 4'(1 << i) : rnd[3:0];
      system_isol_sw <= (i > 5) ? 2'(i - 5) : 2'b00;
      settle();
      {loop_isol_sw, system_isol_sw} <= '0;
      rd(ISRB_OUTPUTS_OFS, lp_m, (i > 5) ? lp_m : 32'(loop_isol_sw) << ISRB_RA_ISOL_POS);
      wb(1'b1, ISRB_REALIGN_OFS, lp_m, 4'hF);
    end
    cyc(4);
    final_report();
  end
endmodule
